// File: src/ram_parity_pkg.sv
package ram_parity_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int BYTES = DATA_W / 8;
   localparam int RAM_AW = 10;
   localparam int RAM_DEPTH = 1 << RAM_AW;
   // Register byte addresses on the APB
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 20'hf00f5 & 20'hffffc;
   localparam logic [ADDR_W-1:0] CTRL_INDEX = 20'hf00f5;
   localparam logic [ADDR_W-1:0] CAUSE_ADDR = 20'hf00f8;
   localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 20'hf00fc;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 20'hf0100;
   localparam logic [ADDR_W-1:0] RAM_BASE = 20'h00000;
   localparam logic [ADDR_W-1:0] RAM_SPAN = 20'h01000;
   // Control register fields
   localparam int MASK_BIT = 7;
   localparam int FLAG_BIT = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int ENABLE_BIT = 1;
   // Reset cause register fields
   localparam int CAUSE_MEM_BIT = 0;
   localparam logic [7:0] CAUSE_RESET = 8'h00;
   localparam int IRQ_ERR_BIT = 0;
   localparam int IRQ_W = 1;
   localparam int RESET_PULSE_CYCLES = 4;
   typedef enum {RST_IDLE, RST_PULSE} rst_state_type;
endpackage

// File: src/ram_parity_if.sv
`timescale 1ns/1ps
interface ram_parity_if;
   import ram_parity_pkg::*;
   logic wr_en;
   logic rd_en;
   logic [RAM_AW-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [BYTES-1:0] wstrb;
   logic [DATA_W-1:0] rdata;
   logic [BYTES-1:0] bad_bytes;
   modport ctrl (output wr_en, rd_en, addr, wdata, wstrb, input rdata, bad_bytes);
   modport store (input wr_en, rd_en, addr, wdata, wstrb, output rdata, bad_bytes);
endinterface

// File: src/ram_parity_store.sv
`timescale 1ns/1ps
module ram_parity_store (
   input wire logic i_core_clk,
   input wire logic i_parity_on,
   ram_parity_if.store bus
);
   import ram_parity_pkg::*;
   logic [DATA_W-1:0] mem [RAM_DEPTH];
   logic [BYTES-1:0] par [RAM_DEPTH];
   logic [DATA_W-1:0] rdata_q;
   logic [BYTES-1:0] rpar_q;
   logic check_q;
   logic [BYTES-1:0] wpar;

   function automatic logic [BYTES-1:0] byte_parity(input logic [DATA_W-1:0] d);
      logic [BYTES-1:0] p;
      p = '0;
      for (int i = 0; i < BYTES; i++) begin
         p[i] = ^d[i*8 +: 8];
      end
      return p;
   endfunction

   assign wpar = byte_parity(bus.wdata);
   assign bus.rdata = rdata_q;
   // Compare on the cycle after the read, against the stored bits
   assign bus.bad_bytes = check_q ? (byte_parity(rdata_q) ^ rpar_q) : '0;

   // No reset: plain RAM array
   always_ff @(posedge i_core_clk) begin
      for (int i = 0; i < BYTES; i++) begin
         if (bus.wr_en && bus.wstrb[i]) begin
            mem[bus.addr][i*8 +: 8] <= bus.wdata[i*8 +: 8];
            // Parity only follows writes while checking is on
            if (i_parity_on) begin
               par[bus.addr][i] <= wpar[i];
            end
         end
      end
      if (bus.rd_en) begin
         rdata_q <= mem[bus.addr];
         rpar_q <= par[bus.addr];
      end
      check_q <= bus.rd_en && i_parity_on;
   end
endmodule

// File: src/ram_parity_checker.sv
`timescale 1ns/1ps
module ram_parity_checker (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ram_parity_pkg::ADDR_W-1:0] i_paddr,
   input wire logic [ram_parity_pkg::DATA_W-1:0] i_pwdata,
   input wire logic [ram_parity_pkg::BYTES-1:0] i_pstrb,
   input wire logic i_pfetch,
   output logic [ram_parity_pkg::DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_internal_reset,
   output logic o_irq
);
   import ram_parity_pkg::*;

   ram_parity_if ram_bus ();
   rst_state_type rst_state_q, rst_state_d;

   logic mask_q, mask_d;
   logic flag_q, flag_d;
   logic enable_q, enable_d;
   logic cause_q, cause_d;
   logic irq_stat_q, irq_stat_d;
   logic irq_mask_q, irq_mask_d;
   logic [2:0] pulse_cnt_q, pulse_cnt_d;
   logic rd_wait_q;
   logic [DATA_W-1:0] prdata_q, prdata_d;
   logic ready_q;

   wire setup = i_psel && !i_penable;
   wire access = i_psel && i_penable;
   wire [ADDR_W-1:0] word_addr = {i_paddr[ADDR_W-1:2], 2'b00};
   wire hit_ctrl = (word_addr == CTRL_ADDR);
   wire hit_cause = (word_addr == CAUSE_ADDR);
   wire hit_stat = (word_addr == IRQ_STAT_ADDR);
   wire hit_mask = (word_addr == IRQ_MASK_ADDR);
   wire hit_ram = (i_paddr >= RAM_BASE) && (i_paddr < RAM_BASE + RAM_SPAN);
   wire hit_any = hit_ctrl || hit_cause || hit_stat || hit_mask || hit_ram;
   // Control register sits in byte lane 1 of its word
   wire [1:0] ctrl_lane = CTRL_INDEX[1:0];
   wire [7:0] ctrl_wbyte = i_pwdata[ctrl_lane*8 +: 8];
   wire ctrl_we = access && ready_q && i_pwrite && hit_ctrl && i_pstrb[ctrl_lane];
   wire reg_we = access && ready_q && i_pwrite;
   wire reg_re = access && ready_q && !i_pwrite;
   // Instruction fetches bypass the checker
   wire data_read = setup && !i_pwrite && hit_ram && !i_pfetch;
   wire any_read = setup && !i_pwrite && hit_ram;
   wire parity_err = |ram_bus.bad_bytes;
   wire fire_reset = parity_err && !mask_q;
   // Checking enable is write-only so the register still reads 00 after reset
   wire [7:0] ctrl_read = {mask_q, 6'b000000, flag_q};

   // RAM reads start in the APB setup phase, writes in the access cycle; read data lands next cycle
   assign ram_bus.wr_en = access && ready_q && i_pwrite && hit_ram;
   assign ram_bus.rd_en = any_read;
   assign ram_bus.addr = i_paddr[RAM_AW+1:2];
   assign ram_bus.wdata = i_pwdata;
   assign ram_bus.wstrb = i_pstrb;

   ram_parity_store store_u (
      .i_core_clk(i_core_clk),
      .i_parity_on(enable_q && (data_read || ram_bus.wr_en)),
      .bus(ram_bus.store)
   );

   // Register and reset-request next state
   always_comb begin
      mask_d = mask_q;
      flag_d = flag_q;
      enable_d = enable_q;
      cause_d = cause_q;
      irq_stat_d = irq_stat_q;
      irq_mask_d = irq_mask_q;
      rst_state_d = rst_state_q;
      pulse_cnt_d = pulse_cnt_q;
      if (ctrl_we) begin
         mask_d = ctrl_wbyte[MASK_BIT];
         flag_d = ctrl_wbyte[FLAG_BIT];
         enable_d = ctrl_wbyte[ENABLE_BIT];
      end
      if (reg_we && hit_cause && i_pstrb[0]) begin
         cause_d = i_pwdata[CAUSE_MEM_BIT];
      end
      if (reg_we && hit_mask && i_pstrb[0]) begin
         irq_mask_d = i_pwdata[IRQ_ERR_BIT];
      end
      // Read of the status clears it
      if (reg_re && hit_stat) begin
         irq_stat_d = 1'b0;
      end
      // Hardware set wins over any software clear
      if (parity_err) begin
         flag_d = 1'b1;
         irq_stat_d = 1'b1;
      end
      case (rst_state_q)
         RST_IDLE: begin
            if (fire_reset) begin
               rst_state_d = RST_PULSE;
               pulse_cnt_d = 3'(RESET_PULSE_CYCLES - 1);
               cause_d = 1'b1;
            end
         end
         RST_PULSE: begin
            if (pulse_cnt_q == 3'd0) begin
               rst_state_d = RST_IDLE;
            end else begin
               pulse_cnt_d = pulse_cnt_q - 3'd1;
            end
         end
         default: rst_state_d = RST_IDLE;
      endcase
   end

   // APB read mux, captured at the setup phase
   always_comb begin
      prdata_d = '0;
      if (hit_ctrl) begin
         prdata_d[ctrl_lane*8 +: 8] = ctrl_read;
      end else if (hit_cause) begin
         prdata_d[CAUSE_MEM_BIT] = cause_q;
      end else if (hit_stat) begin
         prdata_d[IRQ_ERR_BIT] = irq_stat_q;
      end else if (hit_mask) begin
         prdata_d[IRQ_ERR_BIT] = irq_mask_q;
      end
   end

   assign o_pready = ready_q;
   assign o_pslverr = access && ready_q && !hit_any;
   // RAM word stands in the store's output register during the access cycle
   assign o_prdata = rd_wait_q ? ram_bus.rdata : prdata_q;
   assign o_internal_reset = (rst_state_q == RST_PULSE);
   assign o_irq = irq_stat_q && irq_mask_q;

   // Internal reset does not clear the block's own registers, so the cause survives
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         mask_q <= CTRL_RESET[MASK_BIT];
         flag_q <= CTRL_RESET[FLAG_BIT];
         enable_q <= 1'b1;
         cause_q <= CAUSE_RESET[CAUSE_MEM_BIT];
         irq_stat_q <= 1'b0;
         irq_mask_q <= 1'b0;
         rst_state_q <= RST_IDLE;
         pulse_cnt_q <= 3'd0;
      end else begin
         mask_q <= mask_d;
         flag_q <= flag_d;
         enable_q <= enable_d;
         cause_q <= cause_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         rst_state_q <= rst_state_d;
         pulse_cnt_q <= pulse_cnt_d;
      end
   end

   // No wait state: pready comes in the first access cycle, when RAM read data arrives
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ready_q <= 1'b0;
         rd_wait_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         ready_q <= setup;
         rd_wait_q <= any_read;
         if (setup) begin
            prdata_q <= prdata_d;
         end else if (rd_wait_q) begin
            prdata_q <= ram_bus.rdata;
         end
      end
   end
endmodule

// File: verification/ram_parity_properties.sv
`timescale 1ns/1ps
module ram_parity_properties (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ram_parity_pkg::ADDR_W-1:0] i_paddr,
   input wire logic i_pfetch,
   input wire logic [ram_parity_pkg::DATA_W-1:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_internal_reset,
   input wire logic o_irq
);
   import ram_parity_pkg::*;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   ready_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
      else $error("pready missing after setup");
   ready_single_a: assert property (o_pready |=> !o_pready)
      else $error("pready longer than one cycle");
   ready_in_access_a: assert property (o_pready |-> i_psel && i_penable)
      else $error("pready outside access");
   unmapped_refused_a: assert property (o_pslverr |-> o_pready && (i_pwrite || o_prdata == '0))
      else $error("bad refusal");
   reset_pulse_a: assert property ($rose(o_internal_reset) |-> o_internal_reset[*4] ##1 !o_internal_reset)
      else $error("internal reset pulse length wrong");
   reset_cause_a: assert property ($rose(o_internal_reset) |->
      $past(o_pready && !i_pwrite && !i_pfetch && i_paddr < RAM_SPAN))
      else $error("internal reset without data read");
   irq_rise_a: assert property ($rose(o_irq) |-> $past(o_pready))
      else $error("irq rose without access");
   irq_fall_a: assert property ($fell(o_irq) |-> $past(o_pready && !o_pslverr))
      else $error("irq fell without access");
endmodule
bind ram_parity_checker ram_parity_properties props_u (.i_core_clk, .i_resetn, .i_psel,
   .i_penable, .i_pwrite, .i_paddr, .i_pfetch, .o_prdata, .o_pready, .o_pslverr,
   .o_internal_reset, .o_irq);

// File: verification/cpu_bus_model.sv
`timescale 1ns/1ps
module cpu_bus_model (
   input wire logic i_core_clk,
   input wire logic i_pready,
   input wire logic i_pslverr,
   input wire logic [ram_parity_pkg::DATA_W-1:0] i_prdata,
   output logic o_psel = 1'b0,
   output logic o_penable = 1'b0,
   output logic o_pwrite = 1'b0,
   output logic o_pfetch = 1'b0,
   output logic [ram_parity_pkg::ADDR_W-1:0] o_paddr = '0,
   output logic [ram_parity_pkg::DATA_W-1:0] o_pwdata = '0,
   output logic [ram_parity_pkg::BYTES-1:0] o_pstrb = '1
);
   import ram_parity_pkg::*;
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      input logic f, output logic [DATA_W-1:0] rd, output logic err);
      @(posedge i_core_clk);
      o_psel <= 1'b1;
      o_pwrite <= wr;
      o_paddr <= a;
      o_pwdata <= d;
      o_pfetch <= f;
      @(posedge i_core_clk);
      o_penable <= 1'b1;
      do @(posedge i_core_clk); while (i_pready !== 1'b1);
      rd = i_prdata;
      err = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      // Released lines must not look like a held request
      o_paddr <= ~a;
      o_pwdata <= ~d;
   endtask
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   import ram_parity_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic psel, penable, pwrite, pfetch, pready, pslverr, irq, int_rst, err;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [BYTES-1:0] pstrb;
   int bad_count = 0;
   int check_count = 0;
   int cycles = 0;
   always #5 i_core_clk = ~i_core_clk;
   cpu_bus_model bus_u (.i_core_clk, .i_pready(pready), .i_pslverr(pslverr), .i_prdata(prdata),
      .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_pfetch(pfetch),
      .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb));
   ram_parity_checker dut_u (.i_core_clk, .i_resetn, .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .i_pfetch(pfetch),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_internal_reset(int_rst),
      .o_irq(irq));
   task automatic chk(input string what, input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reset_values_test;
      bus_u.xfer(1'b0, CTRL_ADDR, '0, 1'b0, rd, err);
      chk("control", rd[15:8], CTRL_RESET);
      bus_u.xfer(1'b0, 20'h80000, '0, 1'b0, rd, err);
      chk("unmapped", {err, rd}, {1'b1, 32'h0});
      bus_u.xfer(1'b1, 20'h00010, 32'h5a3c96e1, 1'b0, rd, err);
      bus_u.xfer(1'b0, 20'h00010, '0, 1'b0, rd, err);
      #1 chk("ram word", rd, 32'h5a3c96e1);
      chk("clean read", {int_rst, irq}, 2'b00);
   endtask
   task automatic error_test(input logic mask);
      bus_u.xfer(1'b1, IRQ_MASK_ADDR, 32'h1, 1'b0, rd, err);
      bus_u.xfer(1'b1, 20'h00020, 32'h0f0f0f0f, 1'b0, rd, err);
      // Checking off leaves stale parity behind the next write
      bus_u.xfer(1'b1, CTRL_ADDR, {16'h0, mask, 15'h0}, 1'b0, rd, err);
      bus_u.xfer(1'b1, 20'h00020, 32'h0e0e0e0e, 1'b0, rd, err);
      bus_u.xfer(1'b1, CTRL_ADDR, {16'h0, mask, 5'h0, 2'b10, 8'h0}, 1'b0, rd, err);
      bus_u.xfer(1'b0, 20'h00020, '0, 1'b1, rd, err);
      #1 chk("fetch read", {int_rst, irq}, 2'b00);
      bus_u.xfer(1'b0, 20'h00020, '0, 1'b0, rd, err);
      #1 chk("reset out", int_rst, !mask);
      chk("irq set", irq, 1'b1);
      repeat (4) @(posedge i_core_clk);
      bus_u.xfer(1'b0, CTRL_ADDR, '0, 1'b0, rd, err);
      chk("control flag", rd[15:8], {mask, 6'h0, 1'b1});
      bus_u.xfer(1'b0, CAUSE_ADDR, '0, 1'b0, rd, err);
      chk("cause", rd[CAUSE_MEM_BIT], !mask);
      bus_u.xfer(1'b0, IRQ_STAT_ADDR, '0, 1'b0, rd, err);
      #1 chk("status", {rd[IRQ_ERR_BIT], irq}, 2'b10);
      bus_u.xfer(1'b1, CTRL_ADDR, 32'h00000200, 1'b0, rd, err);
      bus_u.xfer(1'b0, CTRL_ADDR, '0, 1'b0, rd, err);
      chk("flag clear", rd[15:8], 8'h00);
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge i_core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (16) @(posedge i_core_clk);
      i_resetn <= 1'b1;
      reset_values_test();
      error_test(1'b1);
      error_test(1'b0);
      print_verdict();
   end
endmodule
